// file: ecr_crc_engine.sv
// crc engine with avalon register slave and apb bus snooping
//
// Functional notes
// - 32-bit mode uses fixed polynomial 04C11DB7
// - 16-bit mode polynomial fully programmable
// - firmware data write updates running crc
// - snoop folds selected peripheral's apb data
// - optional bit reversal within each input byte
// - optional byte reordering of input word
// - optional result bit reversal, word/half-word
// - one control write configures and seeds
// - 32/16/8-bit block folded per cycle
// - one 32/16/8-bit block per data write, at least one wait cycle each
// - dma feeds data writes, firmware request mode
// - registers inaccessible while bus clock gated
// - bus clock full or half system rate
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`include "ecr_regs.svh"

module ecr_crc_engine
   import ecr_pkg::*;
#(
   parameter int SNP_AW = 32
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   // clock gating and rate of the peripheral bus clock
   input wire logic apb_clk_en,
   input wire logic apb_half_rate,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // snooped apb traffic
   input wire logic snp_psel,
   input wire logic snp_penable,
   input wire logic snp_pready,
   input wire logic snp_pwrite,
   input wire logic [SNP_AW-1:0] snp_paddr,
   input wire logic [31:0] snp_pwdata,
   input wire logic [31:0] snp_prdata
);

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   logic [31:0] ctrl_reg, ctrl_next; // configuration
   logic [15:0] poly_reg, poly_next; // programmable 16-bit polynomial
   logic [31:0] snoop_reg, snoop_next; // snooped peripheral base
   logic [31:0] acc_reg, acc_next; // running crc
   logic [31:0] rdata_reg, rdata_next; // read data to the bus
   logic wait_reg, wait_next; // waitrequest
   logic div_reg, div_next; // half-rate divider phase
   logic pclk_en; // one-cycle bus clock enable
   logic wr_take; // write accepted this edge
   logic ctrl_wr, poly_wr, data_wr, snoop_wr;
   logic snp_hit; // completed transfer to the snooped window
   logic feed_valid; // a block enters the crc this cycle
   logic [31:0] raw_word, brev_word, feed_word;
   logic [31:0] eff_poly, res_view;
   logic [31:0] step32_out, step16_out, step8_out, step_sel;
   logic wide32;
   ecr_blk_t blk;

   // ----------------------------------------------------------------------
   // bus clock enable
   // ----------------------------------------------------------------------
   // the bus clock is a synchronous enable, every or every other edge
   always_comb
   begin
      div_next = apb_half_rate ? ~div_reg : 1'b1;
      pclk_en = apb_clk_en & (apb_half_rate ? div_reg : 1'b1);
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         div_reg <= 1'b0;
      end
      else
      begin
         div_reg <= div_next;
      end
   end

   // ----------------------------------------------------------------------
   // avalon slave handshake and read mux
   // ----------------------------------------------------------------------
   // waitrequest drops for one cycle per request; a gated clock never
   // answers, so the master simply waits until the clock returns
   always_comb
   begin
      wait_next = 1'b1;
      rdata_next = rdata_reg;
      if ((avs_read | avs_write) & wait_reg & pclk_en)
      begin
         wait_next = 1'b0;
         if (!avs_read)
         begin
            rdata_next = 32'h00000000;
         end
         else if (avs_address == `ECR_OFS_CTRL)
         begin
            rdata_next = ctrl_reg;
         end
         else if (avs_address == `ECR_OFS_POLY)
         begin
            rdata_next = {16'h0000, poly_reg};
         end
         else if (avs_address == `ECR_OFS_RESULT)
         begin
            rdata_next = res_view;
         end
         else if (avs_address == `ECR_OFS_SNOOP)
         begin
            rdata_next = snoop_reg;
         end
         else
         begin
            // data register is write-only; unmapped reads give zero
            rdata_next = 32'h00000000;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
      end
      else
      begin
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rdata_reg;

   // ----------------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------------
   // a write lands on the edge where waitrequest is seen low
   always_comb
   begin
      wr_take = avs_write & ~wait_reg;
      ctrl_wr = 1'b0;
      poly_wr = 1'b0;
      data_wr = 1'b0;
      snoop_wr = 1'b0;
      if (!wr_take)
      begin
         ctrl_wr = 1'b0;
      end
      else if (avs_address == `ECR_OFS_CTRL)
      begin
         ctrl_wr = 1'b1;
      end
      else if (avs_address == `ECR_OFS_POLY)
      begin
         poly_wr = 1'b1;
      end
      else if (avs_address == `ECR_OFS_DATA)
      begin
         data_wr = 1'b1; // firmware or dma channel
      end
      else if (avs_address == `ECR_OFS_SNOOP)
      begin
         snoop_wr = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // input selection and reordering
   // ----------------------------------------------------------------------
   always_comb
   begin
      // only the access phase with ready counts, once per word
      snp_hit = ctrl_reg[`ECR_CTRL_SNPEN] & pclk_en & snp_psel &
         snp_penable & snp_pready &
         (snp_paddr[SNP_AW-1:`ECR_SNP_WIN_LSB] ==
          snoop_reg[SNP_AW-1:`ECR_SNP_WIN_LSB]) &
         (snp_pwrite != ctrl_reg[`ECR_CTRL_SNPRD]);
      // while snooping, direct data writes are ignored to avoid clashes
      feed_valid = ctrl_reg[`ECR_CTRL_EN] &
         (snp_hit | (data_wr & ~ctrl_reg[`ECR_CTRL_SNPEN]));
      if (snp_hit)
      begin
         raw_word = snp_pwrite ? snp_pwdata : snp_prdata;
      end
      else
      begin
         raw_word = avs_writedata;
      end
      // reverse the bits of each byte
      for (int b = 0; b < 4; b++)
      begin
         for (int k = 0; k < 8; k++)
         begin
            brev_word[8*b+k] = ctrl_reg[`ECR_CTRL_IBREV] ?
               raw_word[8*b+7-k] : raw_word[8*b+k];
         end
      end
   end

   // byte reorder within the active block size
   always_comb
   begin
      blk = ecr_blk_t'(ctrl_reg[`ECR_CTRL_SIZE+1:`ECR_CTRL_SIZE]);
      feed_word = brev_word;
      if (ctrl_reg[`ECR_CTRL_BSWAP])
      begin
         case (blk)
            ECR_BLK32:
            begin
               feed_word = {brev_word[7:0], brev_word[15:8],
                  brev_word[23:16], brev_word[31:24]};
            end
            ECR_BLK16:
            begin
               feed_word = {brev_word[31:16], brev_word[7:0],
                  brev_word[15:8]};
            end
            default:
            begin
               feed_word = brev_word; // a single byte has no order
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // crc datapath
   // ----------------------------------------------------------------------
   always_comb
   begin
      wide32 = ctrl_reg[`ECR_CTRL_MODE32];
      eff_poly = wide32 ? `ECR_POLY32 : {16'h0000, poly_reg};
   end

   // three unrolled widths, one picked per block size
   ecr_crc_step #(.DW(32)) u_step32 (
      .crc_in(acc_reg),
      .poly(eff_poly),
      .wide32(wide32),
      .data(feed_word),
      .crc_out(step32_out)
   );

   ecr_crc_step #(.DW(16)) u_step16 (
      .crc_in(acc_reg),
      .poly(eff_poly),
      .wide32(wide32),
      .data(feed_word[15:0]),
      .crc_out(step16_out)
   );

   ecr_crc_step #(.DW(8)) u_step8 (
      .crc_in(acc_reg),
      .poly(eff_poly),
      .wide32(wide32),
      .data(feed_word[7:0]),
      .crc_out(step8_out)
   );

   // result view: output reversal over word or half-word
   always_comb
   begin
      case (blk)
         ECR_BLK32: step_sel = step32_out;
         ECR_BLK16: step_sel = step16_out;
         default: step_sel = step8_out;
      endcase
      res_view = acc_reg;
      if (ctrl_reg[`ECR_CTRL_OREV])
      begin
         for (int k = 0; k < 32; k++)
         begin
            if (wide32)
            begin
               res_view[k] = acc_reg[31-k];
            end
            else if (k < 16)
            begin
               res_view[k] = acc_reg[15-k];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // configuration and accumulator
   // ----------------------------------------------------------------------
   // a control write wins over a data block arriving the same edge
   always_comb
   begin
      ctrl_next = ctrl_reg;
      poly_next = poly_reg;
      snoop_next = snoop_reg;
      acc_next = acc_reg;
      if (ctrl_wr)
      begin
         ctrl_next = avs_writedata & `ECR_CTRL_MASK;
         acc_next = avs_writedata[`ECR_CTRL_SEED1] ?
            `ECR_SEED_ONES : `ECR_ACC_RST;
         if (!avs_writedata[`ECR_CTRL_MODE32])
         begin
            acc_next[31:16] = 16'h0000;
         end
      end
      else if (feed_valid)
      begin
         acc_next = step_sel;
      end
      if (poly_wr)
      begin
         poly_next = avs_writedata[15:0];
      end
      if (snoop_wr)
      begin
         snoop_next = avs_writedata;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_reg <= `ECR_CTRL_RST;
         poly_reg <= `ECR_POLY_RST;
         snoop_reg <= `ECR_SNOOP_RST;
         acc_reg <= `ECR_ACC_RST;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         poly_reg <= poly_next;
         snoop_reg <= snoop_next;
         acc_reg <= acc_next;
      end
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_fixed_poly: assert property (
      ctrl_reg[`ECR_CTRL_MODE32] |-> eff_poly == 32'h04C11DB7)
      else $error("32-bit mode not on fixed polynomial");

   a_prog_poly: assert property (
      poly_wr ##1 !ctrl_reg[`ECR_CTRL_MODE32] |->
         eff_poly[15:0] == $past(avs_writedata[15:0]))
      else $error("16-bit polynomial not taken from register");

   a_data_fold: assert property (
      (data_wr && !ctrl_wr && ctrl_reg[`ECR_CTRL_EN] &&
         !ctrl_reg[`ECR_CTRL_SNPEN]) |=> acc_reg == $past(step_sel))
      else $error("data write did not update crc");

   a_snoop_fold: assert property (
      (snp_hit && !ctrl_wr && ctrl_reg[`ECR_CTRL_EN]) |=>
         acc_reg == $past(step_sel))
      else $error("snooped transfer not folded");

   a_in_bitrev: assert property (
      ctrl_reg[`ECR_CTRL_IBREV] |->
         (brev_word[0] == raw_word[7] && brev_word[31] == raw_word[24]))
      else $error("input byte bits not reversed");

   a_byte_swap: assert property (
      (ctrl_reg[`ECR_CTRL_BSWAP] && blk == ECR_BLK32) |->
         feed_word[31:24] == brev_word[7:0])
      else $error("input bytes not reordered");

   a_out_rev: assert property (
      (ctrl_reg[`ECR_CTRL_OREV] && wide32) |->
         (res_view[0] == acc_reg[31] && res_view[31] == acc_reg[0]))
      else $error("result not reversed");

   a_ctrl_seed: assert property (
      (ctrl_wr && avs_writedata[`ECR_CTRL_SEED1] &&
         avs_writedata[`ECR_CTRL_MODE32]) |=>
         (acc_reg == 32'hFFFFFFFF && ctrl_reg[`ECR_CTRL_MODE32]))
      else $error("control write did not seed accumulator");

   a_gated_wait: assert property (
      !apb_clk_en |=> avs_waitrequest)
      else $error("answer given while bus clock gated");

   a_half_rate: assert property (
      (apb_half_rate && pclk_en) |=> !div_reg)
      else $error("half-rate enable on consecutive cycles");

   a_acc_quiet: assert property (
      (!ctrl_wr && !feed_valid) |=> $stable(acc_reg))
      else $error("accumulator changed without cause");

   a_one_answer: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

endmodule : ecr_crc_engine

// file: ecr_regs.svh
// register offsets, field positions and reset values of the crc engine
`ifndef ECR_REGS_SVH
`define ECR_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets on the avalon slave
// ----------------------------------------------------------------------
`define ECR_OFS_CTRL 5'h00
`define ECR_OFS_POLY 5'h04
`define ECR_OFS_DATA 5'h08
`define ECR_OFS_RESULT 5'h0C
`define ECR_OFS_SNOOP 5'h10

// ----------------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------------
`define ECR_CTRL_EN 0
`define ECR_CTRL_MODE32 1
`define ECR_CTRL_SIZE 2
`define ECR_CTRL_IBREV 4
`define ECR_CTRL_BSWAP 5
`define ECR_CTRL_OREV 6
`define ECR_CTRL_SNPEN 7
`define ECR_CTRL_SNPRD 8
`define ECR_CTRL_SEED1 9
`define ECR_CTRL_MASK 32'h000003FF

// ----------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------
`define ECR_CTRL_RST 32'h00000000
`define ECR_POLY_RST 16'h1021
`define ECR_SNOOP_RST 32'h00000000
`define ECR_ACC_RST 32'h00000000
`define ECR_POLY32 32'h04C11DB7
`define ECR_SEED_ONES 32'hFFFFFFFF
`define ECR_SNP_WIN_LSB 12

`endif

// file: ecr_pkg.sv
// types shared by the crc engine files
package ecr_pkg;

   // block size of one crc step
   typedef enum logic [1:0] {
      ECR_BLK32,
      ECR_BLK16,
      ECR_BLK8
   } ecr_blk_t;

endpackage : ecr_pkg

// file: ecr_crc_step.sv
// one unrolled crc step over a block of DW data bits
`timescale 1ns/100ps

module ecr_crc_step
   import ecr_pkg::*;
#(
   parameter int DW = 32
)
(
   input wire logic [31:0] crc_in,
   input wire logic [31:0] poly,
   input wire logic wide32,
   input wire logic [DW-1:0] data,
   output logic [31:0] crc_out
);

   // ----------------------------------------------------------------------
   // parallel step
   // ----------------------------------------------------------------------
   // the loop unrolls into xor trees, so a whole block folds in one cycle
   always_comb
   begin
      logic [31:0] c;
      logic fb;
      c = crc_in;
      fb = 1'b0;
      // msb of the block enters first
      for (int i = DW - 1; i >= 0; i--)
      begin
         fb = (wide32 ? c[31] : c[15]) ^ data[i];
         c = {c[30:0], 1'b0};
         if (fb)
         begin
            c = c ^ poly;
         end
      end
      // narrow mode keeps only the low half-word
      if (!wide32)
      begin
         c[31:16] = 16'h0000;
      end
      crc_out = c;
   end

endmodule : ecr_crc_step

// file: ecr_apb_model.sv
// snooped apb bus model: master and addressed peripheral in one
`timescale 1ns/100ps

module ecr_apb_model
(
   input wire logic sys_clk,
   output logic psel,
   output logic penable,
   output logic pready,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   output logic [31:0] prdata
);
   // ---------
   // idle bus
   // ---------
   // handshake low at time zero; data lines carry a junk pattern
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pready = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h00000000;
      pwdata = 32'h5A5A5A5A;
      prdata = 32'hA5A5A5A5;
   end

   // ---------
   // one transfer
   // ---------
   // setup, access with wait states, then release; the caller enters
   // just after a rising edge. released address and data lines show the
   // inverse of the transfer's address and word so that a stale capture cannot match by luck
   task automatic xfer(input logic wr, input logic [31:0] a,
      input logic [31:0] d, input int waits);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wr ? d : ~d;
      @(posedge sys_clk);
      penable <= 1'b1;
      repeat (waits) @(posedge sys_clk);
      pready <= 1'b1; // one completing cycle per word
      prdata <= wr ? ~d : d;
      @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      pready <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      prdata <= ~d;
      // one idle edge, so a following transfer never reassigns a line
      // in the time step of this release
      @(posedge sys_clk);
   endtask : xfer
endmodule : ecr_apb_model

// file: tb_top.sv
// self-checking testbench of the crc engine
`timescale 1ns/100ps
`include "ecr_regs.svh"

module tb_top;
   // ---------
   // signals
   // ---------
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic apb_clk_en = 1'b1;
   logic apb_half_rate = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic psel, penable, pready, pwrite;
   logic [31:0] paddr, pwdata, prdata;
   int error_cnt = 0;
   int num_checks = 0;
   logic [31:0] acc; // bench model of the accumulator
   logic [31:0] rd;
   int waits;

   ecr_crc_engine ecr_crc_engine_i (.sys_clk(sys_clk), .resetn(resetn),
      .apb_clk_en(apb_clk_en), .apb_half_rate(apb_half_rate),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .snp_psel(psel), .snp_penable(penable), .snp_pready(pready),
      .snp_pwrite(pwrite), .snp_paddr(paddr), .snp_pwdata(pwdata),
      .snp_prdata(prdata));

   ecr_apb_model ecr_apb_model_i (.sys_clk(sys_clk), .psel(psel),
      .penable(penable), .pready(pready), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata));

   // 25 mhz clock
   initial
   begin
      forever #20 sys_clk = ~sys_clk;
   end

   // ---------
   // checking and bus helpers
   // ---------
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk32

   // one avalon cycle; holds everything until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q, output int n);
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      @(posedge sys_clk);
      // only the watchdog ends a wait whose answer never comes
      while (avs_waitrequest !== 1'b0)
      begin
         @(posedge sys_clk);
         n++;
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask : bus

   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rd, waits);
   endtask : wr_reg

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000, rd, waits);
      chk32(rd, exp);
   endtask : rd_chk

   // ---------
   // reference crc: msb first, not reflected, no final xor
   // ---------
   function automatic logic [31:0] ref_step(input logic [31:0] c,
      input logic [31:0] ctl, input logic [15:0] p, input logic [31:0] d);
      logic [31:0] x;
      logic fb;
      int nb;
      nb = (ctl[3:2] == 2'b00) ? 32 : (ctl[3:2] == 2'b01) ? 16 : 8;
      x = d;
      // per byte bit reversal comes before the byte swap
      if (ctl[4])
         for (int i = 0; i < 32; i++) x[i] = d[i - i % 8 + 7 - i % 8];
      if (ctl[5] && nb == 32)
         x = {x[7:0], x[15:8], x[23:16], x[31:24]};
      if (ctl[5] && nb == 16)
         x[15:0] = {x[7:0], x[15:8]};
      for (int i = nb - 1; i >= 0; i--)
      begin
         fb = x[i] ^ (ctl[1] ? c[31] : c[15]);
         c = c << 1;
         if (!ctl[1])
            c[31:16] = 16'h0000;
         if (fb)
            c = c ^ (ctl[1] ? `ECR_POLY32 : {16'h0000, p});
      end
      return c;
   endfunction : ref_step

   // result as software reads it
   function automatic logic [31:0] view(input logic [31:0] c,
      input logic [31:0] ctl);
      logic [31:0] r;
      r = c;
      if (ctl[6] && ctl[1])
         for (int i = 0; i < 32; i++) r[i] = c[31 - i];
      else if (ctl[6])
         for (int i = 0; i < 16; i++) r[i] = c[15 - i];
      return r;
   endfunction : view

   // ---------
   // scenarios
   // ---------
   task automatic t_reset;
      rd_chk(`ECR_OFS_CTRL, `ECR_CTRL_RST);
      rd_chk(`ECR_OFS_POLY, {16'h0000, `ECR_POLY_RST});
      rd_chk(`ECR_OFS_SNOOP, `ECR_SNOOP_RST);
      rd_chk(`ECR_OFS_RESULT, `ECR_ACC_RST);
      rd_chk(5'h14, 32'h00000000);
      wr_reg(`ECR_OFS_CTRL, 32'hFFFFFC00);
      rd_chk(`ECR_OFS_CTRL, 32'h00000000);
      wr_reg(`ECR_OFS_RESULT, 32'h12345678);
      rd_chk(`ECR_OFS_RESULT, 32'h00000000);
      rd_chk(`ECR_OFS_DATA, 32'h00000000);
      $display("test reset done");
   endtask : t_reset

   // every mode, block size and reordering option; last row disabled
   task automatic t_modes;
      logic [31:0] ctl [7] = '{32'h203, 32'h273, 32'h225, 32'h265,
         32'h019, 32'h00F, 32'h202};
      logic [15:0] pol [7] = '{16'h8005, 16'h8005, 16'h8005, 16'hC867,
         16'h1021, 16'h8005, 16'h8005};
      logic [31:0] d;
      for (int i = 0; i < 7; i++)
      begin
         wr_reg(`ECR_OFS_POLY, {16'h0000, pol[i]});
         rd_chk(`ECR_OFS_POLY, {16'h0000, pol[i]});
         wr_reg(`ECR_OFS_CTRL, ctl[i]);
         acc = ctl[i][9] ? (ctl[i][1] ? 32'hFFFFFFFF : 32'h0000FFFF) : 0;
         rd_chk(`ECR_OFS_RESULT, view(acc, ctl[i]));
         // back to back feed, as a firmware-request channel would
         for (int j = 0; j < 3; j++)
         begin
            d = 32'hA5C30F1E + j * 32'h13579BDF;
            wr_reg(`ECR_OFS_DATA, d);
            chk32(waits, 32'h00000001);
            if (ctl[i][0])
               acc = ref_step(acc, ctl[i], pol[i], d);
         end
         rd_chk(`ECR_OFS_RESULT, view(acc, ctl[i]));
         rd_chk(`ECR_OFS_RESULT, view(acc, ctl[i]));
      end
      $display("test modes done");
   endtask : t_modes

   // snoop writes, then snoop reads, within one 4 kb window
   task automatic t_snoop;
      wr_reg(`ECR_OFS_SNOOP, 32'h40002000);
      wr_reg(`ECR_OFS_CTRL, 32'h283);
      acc = ref_step(32'hFFFFFFFF, 32'h283, 16'h0000, 32'hCAFE0001);
      ecr_apb_model_i.xfer(1'b1, 32'h40002FFC, 32'hCAFE0001, 2);
      ecr_apb_model_i.xfer(1'b1, 32'h40003000, 32'h11112222, 0);
      ecr_apb_model_i.xfer(1'b0, 32'h40002004, 32'h33334444, 0);
      wr_reg(`ECR_OFS_DATA, 32'h55556666);
      ecr_apb_model_i.xfer(1'b1, 32'h40002000, 32'h0BADF00D, 0);
      acc = ref_step(acc, 32'h283, 16'h0000, 32'h0BADF00D);
      rd_chk(`ECR_OFS_RESULT, acc);
      wr_reg(`ECR_OFS_CTRL, 32'h383);
      acc = ref_step(32'hFFFFFFFF, 32'h383, 16'h0000, 32'h77778888);
      ecr_apb_model_i.xfer(1'b0, 32'h40002010, 32'h77778888, 1);
      ecr_apb_model_i.xfer(1'b1, 32'h40002010, 32'h9999AAAA, 0);
      rd_chk(`ECR_OFS_RESULT, acc);
      $display("test snoop done");
   endtask : t_snoop

   // half rate bus clock, then a gated bus clock that stalls a read
   task automatic t_clock;
      wr_reg(`ECR_OFS_CTRL, 32'h203);
      apb_half_rate <= 1'b1;
      wr_reg(`ECR_OFS_DATA, 32'h0F0F0F0F);
      acc = ref_step(32'hFFFFFFFF, 32'h203, 16'h0000, 32'h0F0F0F0F);
      rd_chk(`ECR_OFS_RESULT, acc);
      chk32(waits, 32'h00000002);
      apb_half_rate <= 1'b0;
      apb_clk_en <= 1'b0;
      fork
         begin
            repeat (8) @(posedge sys_clk);
            apb_clk_en <= 1'b1;
         end
      join_none
      bus(1'b0, `ECR_OFS_RESULT, 32'h00000000, rd, waits);
      chk32(rd, acc);
      chk32({31'h0, waits >= 8}, 32'h00000001);
      $display("test clock done");
   endtask : t_clock

   // ---------
   // verdict and run control
   // ---------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // the tests need about 300 cycles; this limit leaves wide margin
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      give_verdict;
   end

   initial
   begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      t_reset;
      t_modes;
      t_snoop;
      t_clock;
      give_verdict;
   end
endmodule : tb_top
